/* rtl/avs_pkg.sv */
// shared constants and crc for the voltage scaling serial link
package avs_pkg;
  // subframe field codes
  localparam logic [1:0] START_CODE  = 2'h1;
  localparam logic [1:0] ACC_WRITE   = 2'h0;
  localparam logic [1:0] ACC_READ    = 2'h3;
  localparam logic       CTYPE_DATA  = 1'h0;
  localparam logic [1:0] ACK_DONE    = 2'h0;
  localparam logic [1:0] ACK_NOACT   = 2'h1;
  localparam logic [1:0] ACK_BADCRC  = 2'h2;
  localparam logic [1:0] ACK_INVALID = 2'h3;
  localparam logic [3:0] CMD_VTARGET = 4'h0;
  localparam logic [3:0] CMD_RATE    = 4'h1;
  localparam logic [3:0] CMD_CURRENT = 4'h2;
  localparam logic [3:0] CMD_TEMP    = 4'h3;
  localparam logic [3:0] CMD_VRESET  = 4'h4;
  localparam logic [3:0] CMD_STATUS  = 4'he;
  localparam logic [3:0] CMD_VERSION = 4'hf;
  localparam logic [3:0] RAIL0       = 4'h0;
  localparam logic [3:0] RAIL1       = 4'h1;
  localparam logic [3:0] RAIL_ALL    = 4'hf;
  localparam logic [15:0] DATA_ONES  = 16'hffff;
  localparam logic [4:0]  PAD_ONES   = 5'h1f;
  localparam logic [15:0] VERSION_VALUE = 16'h0000;
  // command subframe bit positions
  localparam int POS_START = 30;
  localparam int POS_ACC   = 28;
  localparam int POS_CTYPE = 27;
  localparam int POS_CODE  = 23;
  localparam int POS_RAIL  = 19;
  localparam int POS_DATA  = 3;
  // status entry and response status bits
  localparam int ST_REACHED = 15;
  localparam int ST_OTW     = 12;
  // frame length and counters
  localparam logic [5:0] FRAME_BITS = 6'h20;
  localparam logic [5:0] LAST_PER   = 6'h3f;
  // link clock made by the host from ref_clk
  localparam int REF_CLK_NS     = 40;
  localparam int LINK_PERIOD_NS = 320;
  localparam int LINK_DIV       = LINK_PERIOD_NS / REF_CLK_NS;
  localparam logic [2:0] PH_FALL   = 3'h0;
  localparam logic [2:0] PH_RISE   = 3'(LINK_DIV / 2);
  localparam logic [2:0] PH_SAMPLE = 3'(LINK_DIV * 3 / 4);
  localparam logic [2:0] PH_LAST   = 3'(LINK_DIV - 1);
  // host register map
  localparam logic [7:0] REG_CMD  = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_RESP = 8'h08;
  localparam int CB_RAIL   = 16;
  localparam int CB_CODE   = 20;
  localparam int CB_ACC    = 24;
  localparam int CB_BADCRC = 26;
  localparam int SB_BUSY   = 0;
  localparam int SB_DONE   = 1;
  localparam int SB_CRC_OK = 2;
  localparam int SB_ALERT  = 3;

  // crc over the first 29 bits, msb first, x^3+x+1, seed zero
  function automatic logic [2:0] avs_crc3(input logic [28:0] d);
    logic [2:0] c;
    logic       fb;
    c = 3'h0;
    for (int i = 28; i >= 0; i--)
    begin
      fb = d[i] ^ c[2];
      c  = {c[1], c[0] ^ fb, fb};
    end
    return c;
  endfunction : avs_crc3
endpackage : avs_pkg

/* rtl/avs_link_if.sv */
// three-wire link between the bus master and the regulator slave
`timescale 1ns/1ps
interface avs_link_if;
  logic avs_clk;
  logic mdata;
  logic sdata;
  modport dev  (input avs_clk, input mdata, output sdata);
  modport host (output avs_clk, output mdata, input sdata);
endinterface : avs_link_if

/* rtl/avs_link_sampler.sv */
// synchronises link clock and master data, finds link clock edges
`timescale 1ns/1ps
module avs_link_sampler
  import avs_pkg::*;
(
  // system
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // link pins
  input  wire logic avs_clk,
  input  wire logic mdata,
  // sampled view
  output logic      clk_rise,
  output logic      clk_fall,
  output logic      mdata_s
);
  typedef struct packed {
    logic [2:0] ck;
    logic [1:0] md;
  } avs_smp_t;

  avs_smp_t q_ff;
  avs_smp_t nxt_q;

  always_comb
  begin
    nxt_q    = q_ff;
    nxt_q.ck = {q_ff.ck[1:0], avs_clk};
    nxt_q.md = {q_ff.md[0], mdata};
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      q_ff <= '{ck: 3'h7, md: 2'h3};
    else
      q_ff <= nxt_q;
  end

  // stage 0 is never looked at; data stays aligned with the clock view
  assign clk_rise = q_ff.ck[1] & ~q_ff.ck[2];
  assign clk_fall = ~q_ff.ck[1] & q_ff.ck[2];
  assign mdata_s  = q_ff.md[1];
endmodule : avs_link_sampler

/* rtl/avs_dev_end.sv */
// regulator side of the voltage scaling link: decode, entries, response
//
// Behaviour
// - link clock up to 50MHz, set by master
// - reads always served; writes only under control
// - command: start,acc,type,code,rail,data,crc in order
// - start 01b, access 00b write, 11b read
// - code picks entry; unknown codes are invalid
// - rail 0h, 1h; Fh broadcasts to both
// - master reads with data field all ones
// - response: ack,zero,status,data,pad,crc in order
// - ack 00b acted, 01b accepted without action
// - bad crc answers 10b, nothing changes
// - invalid request answers 11b, nothing changes
// - status bit4 shows target voltage reached
// - status bit3 flags other status entry bits
// - status bit2 shows bus control; 1:0 zero
// - write answers all-ones data; pad 11111b
// - data line pulled low to alert host
// - status entry: bit15 reached, bit12 overtemp
// - target in mV, seeded from setpoint
`timescale 1ns/1ps
module avs_dev_end
  import avs_pkg::*;
(
  // system
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  // link
  avs_link_if.dev                link,
  // regulator side, per rail
  input  wire logic [1:0]        bus_ctrl,
  input  wire logic [1:0][15:0]  output_voltage_setpoint,
  input  wire logic [1:0]        target_reached_flag,
  input  wire logic [1:0]        over_temperature_warning,
  input  wire logic [1:0][15:0]  rail_current,
  input  wire logic [1:0][15:0]  rail_temp,
  output logic      [1:0][15:0]  target_mv,
  output logic      [1:0][15:0]  trans_rate
);
  typedef enum logic [2:0] {
    DS_IDLE = 3'b001,
    DS_RX   = 3'b010,
    DS_TX   = 3'b100
  } avs_dst_t;

  typedef struct packed {
    avs_dst_t        st;
    logic [5:0]      cnt;
    logic [31:0]     sh;
    logic [1:0][15:0] tgt;
    logic [1:0][15:0] rate;
    logic [1:0]      ctrl_q;
    logic [3:0]      stat_q;
    logic            alert;
    logic            sdata;
  } avs_dev_t;

  avs_dev_t q_ff;
  avs_dev_t nxt_q;

  logic        clk_rise;
  logic        clk_fall;
  logic        mdata_s;
  logic [31:0] w;
  logic [1:0]  acc;
  logic [3:0]  code;
  logic [3:0]  rail;
  logic [15:0] wdat;
  logic        ri;
  logic [1:0]  hit;
  logic        rail_ok;
  logic        hdr_ok;
  logic        rd_ok;
  logic        wr_ok;
  logic        changed;
  logic [15:0] rdat;
  logic [15:0] nv;
  logic [1:0]  ack;
  logic [4:0]  rstat;
  logic [28:0] rsp;
  logic [3:0]  stat_now;
  logic        alert_set;
  logic        alert_clr;

  avs_link_sampler u_smp (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .avs_clk  (link.avs_clk),
    .mdata    (link.mdata),
    .clk_rise (clk_rise),
    .clk_fall (clk_fall),
    .mdata_s  (mdata_s)
  );

  always_comb
  begin
    nxt_q = q_ff;
    // command word as it stands once the last bit arrives
    w       = {q_ff.sh[30:0], mdata_s};
    acc     = w[POS_ACC +: 2];
    code    = w[POS_CODE +: 4];
    rail    = w[POS_RAIL +: 4];
    wdat    = w[POS_DATA +: 16];
    hdr_ok  = (w[POS_START +: 2] == START_CODE) && (w[POS_CTYPE] == CTYPE_DATA);
    hit[0]  = (rail == RAIL0) || (rail == RAIL_ALL);
    hit[1]  = (rail == RAIL1) || (rail == RAIL_ALL);
    rail_ok = |hit;
    // broadcast reads answer with rail 0
    ri      = (rail == RAIL1);
    rd_ok   = 1'b1;
    case (code)
      CMD_VTARGET: rdat = q_ff.tgt[ri];
      CMD_RATE:    rdat = q_ff.rate[ri];
      CMD_CURRENT: rdat = rail_current[ri];
      CMD_TEMP:    rdat = rail_temp[ri];
      CMD_STATUS:
      begin
        rdat             = 16'h0000;
        rdat[ST_REACHED] = target_reached_flag[ri];
        rdat[ST_OTW]     = over_temperature_warning[ri];
      end
      CMD_VERSION: rdat = VERSION_VALUE;
      default:
      begin
        rdat  = DATA_ONES;
        rd_ok = 1'b0;
      end
    endcase
    // every addressed rail must be under bus control
    wr_ok = ((code == CMD_VTARGET) || (code == CMD_RATE) || (code == CMD_VRESET))
            && (~hit[0] | bus_ctrl[0]) && (~hit[1] | bus_ctrl[1]);
    changed = 1'b0;
    nv      = wdat;
    for (int i = 0; i < 2; i++)
    begin
      if (hit[i])
      begin
        if (code == CMD_RATE)
          changed = changed | (q_ff.rate[i] != wdat);
        else if (code == CMD_VRESET)
          changed = changed | (q_ff.tgt[i] != output_voltage_setpoint[i]);
        else
          changed = changed | (q_ff.tgt[i] != wdat);
      end
    end
    if (avs_crc3(w[31:3]) != w[2:0])
      ack = ACK_BADCRC;
    else if (!hdr_ok || !rail_ok)
      ack = ACK_INVALID;
    else if (acc == ACC_READ)
      ack = rd_ok ? ACK_DONE : ACK_INVALID;
    else if (acc == ACC_WRITE && wr_ok)
      ack = changed ? ACK_DONE : ACK_NOACT;
    else
      ack = ACK_INVALID;
    rstat = {target_reached_flag[ri], over_temperature_warning[ri],
             bus_ctrl[ri], 2'h0};
    rsp   = {ack, 1'b0, rstat,
             ((acc == ACC_READ) && (ack == ACK_DONE)) ? rdat : DATA_ONES,
             PAD_ONES};

    // entering bus control seeds the target from the setpoint
    for (int i = 0; i < 2; i++)
    begin
      if (bus_ctrl[i] && !q_ff.ctrl_q[i])
        nxt_q.tgt[i] = output_voltage_setpoint[i];
    end
    nxt_q.ctrl_q = bus_ctrl;

    // a newly set status bit raises the alert; reading status clears it
    stat_now     = {target_reached_flag, over_temperature_warning};
    alert_set    = |(stat_now & ~q_ff.stat_q);
    alert_clr    = 1'b0;
    nxt_q.stat_q = stat_now;

    case (q_ff.st)
      DS_IDLE:
      begin
        nxt_q.sdata = ~q_ff.alert;
        if (clk_rise && !mdata_s)
        begin
          nxt_q.st    = DS_RX;
          nxt_q.sh    = {31'h0, mdata_s};
          nxt_q.cnt   = 6'h1;
          nxt_q.sdata = 1'b1;
        end
      end
      DS_RX:
      begin
        if (clk_rise)
        begin
          nxt_q.sh  = w;
          nxt_q.cnt = q_ff.cnt + 6'h1;
          if (q_ff.cnt == FRAME_BITS - 6'h1)
          begin
            nxt_q.st  = DS_TX;
            nxt_q.cnt = 6'h0;
            nxt_q.sh  = {rsp, avs_crc3(rsp)};
            if (acc == ACC_WRITE && ack == ACK_DONE)
            begin
              for (int i = 0; i < 2; i++)
              begin
                if (hit[i] && code == CMD_RATE)
                  nxt_q.rate[i] = wdat;
                else if (hit[i] && code == CMD_VRESET)
                  nxt_q.tgt[i] = output_voltage_setpoint[i];
                else if (hit[i])
                  nxt_q.tgt[i] = nv;
              end
            end
            alert_clr = (acc == ACC_READ) && (code == CMD_STATUS) && (ack == ACK_DONE);
          end
        end
      end
      DS_TX:
      begin
        if (clk_fall && q_ff.cnt != FRAME_BITS)
        begin
          nxt_q.sdata = q_ff.sh[31];
          nxt_q.sh    = {q_ff.sh[30:0], 1'b1};
          nxt_q.cnt   = q_ff.cnt + 6'h1;
        end
        else if (clk_rise && q_ff.cnt == FRAME_BITS)
        begin
          nxt_q.st    = DS_IDLE;
          nxt_q.sdata = ~q_ff.alert;
        end
      end
      default:
      begin
        nxt_q.st    = DS_IDLE;
        nxt_q.sdata = 1'b1;
      end
    endcase
    // a new event in the clearing cycle keeps the alert up
    nxt_q.alert = (q_ff.alert & ~alert_clr) | alert_set;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q_ff        <= '0;
      q_ff.st     <= DS_IDLE;
      q_ff.sdata  <= 1'b1;
    end
    else
      q_ff <= nxt_q;
  end

  assign link.sdata = q_ff.sdata;
  assign target_mv  = q_ff.tgt;
  assign trans_rate = q_ff.rate;
endmodule : avs_dev_end

/* rtl/avs_host_end.sv */
// bus master side: wishbone registers in, one command/response frame out
`timescale 1ns/1ps
module avs_host_end
  import avs_pkg::*;
(
  // system
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // wishbone classic slave
  input  wire logic        wb_cyc,
  input  wire logic        wb_stb,
  input  wire logic        wb_we,
  input  wire logic [3:0]  wb_sel,
  input  wire logic [7:0]  wb_adr,
  input  wire logic [31:0] wb_dat_wr,
  output logic      [31:0] wb_dat_rd,
  output logic             wb_ack,
  // link
  avs_link_if.host         link
);
  typedef enum logic [1:0] {
    HS_IDLE = 2'b01,
    HS_RUN  = 2'b10
  } avs_hst_t;

  typedef struct packed {
    avs_hst_t    st;
    logic [2:0]  ph;
    logic [5:0]  per;
    logic [31:0] tx;
    logic [31:0] rx;
    logic [31:0] resp;
    logic [1:0]  sd;
    logic        lclk;
    logic        mdata;
    logic        done;
    logic        ack;
    logic [31:0] rdat;
  } avs_host_t;

  avs_host_t   q_ff;
  avs_host_t   nxt_q;
  logic [1:0]  acc;
  logic [28:0] f29;

  always_comb
  begin
    nxt_q     = q_ff;
    nxt_q.sd  = {q_ff.sd[0], link.sdata};
    nxt_q.ack = 1'b0;
    acc       = wb_dat_wr[CB_ACC +: 2];
    // reads always carry all ones; start code and type are fixed
    f29 = {START_CODE, acc, CTYPE_DATA, wb_dat_wr[CB_CODE +: 4],
           wb_dat_wr[CB_RAIL +: 4],
           (acc == ACC_READ) ? DATA_ONES : wb_dat_wr[15:0]};

    if (wb_cyc && wb_stb && !q_ff.ack)
    begin
      nxt_q.ack  = 1'b1;
      nxt_q.rdat = 32'h0;
      case (wb_adr)
        REG_STAT:
        begin
          nxt_q.rdat[SB_BUSY]   = (q_ff.st == HS_RUN);
          nxt_q.rdat[SB_DONE]   = q_ff.done;
          nxt_q.rdat[SB_CRC_OK] = (avs_crc3(q_ff.resp[31:3]) == q_ff.resp[2:0]);
          // only meaningful between frames
          nxt_q.rdat[SB_ALERT]  = ~q_ff.sd[1] && (q_ff.st == HS_IDLE);
        end
        REG_RESP:
          nxt_q.rdat = q_ff.resp;
        default:
          nxt_q.rdat = 32'h0;
      endcase
      // a command written while a frame runs is dropped
      if (wb_we && wb_adr == REG_CMD && q_ff.st == HS_IDLE)
      begin
        // spoil bit inverts the crc so the device's refusal path can be exercised
        nxt_q.tx   = {f29, avs_crc3(f29) ^ {3{wb_dat_wr[CB_BADCRC]}}};
        nxt_q.st   = HS_RUN;
        nxt_q.ph   = PH_FALL;
        nxt_q.per  = 6'h0;
        nxt_q.done = 1'b0;
      end
    end

    case (q_ff.st)
      HS_IDLE:
      begin
        nxt_q.lclk  = 1'b1;
        nxt_q.mdata = 1'b1;
      end
      HS_RUN:
      begin
        nxt_q.ph = q_ff.ph + 3'h1;
        if (q_ff.ph == PH_FALL)
        begin
          nxt_q.lclk = 1'b0;
          if (q_ff.per < FRAME_BITS)
          begin
            nxt_q.mdata = q_ff.tx[31];
            nxt_q.tx    = {q_ff.tx[30:0], 1'b1};
          end
          else
            nxt_q.mdata = 1'b1;
        end
        else if (q_ff.ph == PH_RISE)
          nxt_q.lclk = 1'b1;
        else if (q_ff.ph == PH_SAMPLE && q_ff.per >= FRAME_BITS)
          nxt_q.rx = {q_ff.rx[30:0], q_ff.sd[1]};
        else if (q_ff.ph == PH_LAST)
        begin
          nxt_q.per = q_ff.per + 6'h1;
          if (q_ff.per == LAST_PER)
          begin
            nxt_q.st   = HS_IDLE;
            nxt_q.resp = q_ff.rx;
            nxt_q.done = 1'b1;
          end
        end
      end
      default:
        nxt_q.st = HS_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q_ff       <= '0;
      q_ff.st    <= HS_IDLE;
      q_ff.sd    <= 2'h3;
      q_ff.lclk  <= 1'b1;
      q_ff.mdata <= 1'b1;
    end
    else
      q_ff <= nxt_q;
  end

  assign wb_ack       = q_ff.ack;
  assign wb_dat_rd    = q_ff.rdat;
  assign link.avs_clk = q_ff.lclk;
  assign link.mdata   = q_ff.mdata;
endmodule : avs_host_end

/* verif/avs_link_chk_sva.sv */
// wire-level checks of the voltage scaling link between host and device ends
`timescale 1ns/1ps
module avs_link_chk
(
  // system
  input wire logic ref_clk,
  input wire logic rst_n,
  // link
  input wire logic avs_clk,
  input wire logic mdata,
  input wire logic sdata
);
  logic       clk_q_ff;
  logic [2:0] hi_cnt_ff;
  logic [6:0] rise_cnt_ff;
  logic       rd_cmd_ff;
  logic       clk_rise;
  logic       clk_fall;
  logic       frame_end;

  assign clk_rise  = avs_clk && !clk_q_ff;
  assign clk_fall  = !avs_clk && clk_q_ff;
  // in a frame the clock is high for only four cycles, so a fifth marks idle
  assign frame_end = avs_clk && (hi_cnt_ff == 3'h4);

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clk_q_ff    <= 1'b1;
      hi_cnt_ff   <= 3'h0;
      rise_cnt_ff <= 7'h00;
      rd_cmd_ff   <= 1'b0;
    end
    else
    begin
      clk_q_ff    <= avs_clk;
      hi_cnt_ff   <= !avs_clk ? 3'h0 : ((hi_cnt_ff == 3'h7) ? hi_cnt_ff : hi_cnt_ff + 3'h1);
      rise_cnt_ff <= frame_end ? 7'h00 : (clk_rise ? rise_cnt_ff + 7'h01 : rise_cnt_ff);
      // upper access bit of the command marks a read
      rd_cmd_ff   <= (clk_fall && rise_cnt_ff == 7'h02) ? mdata : rd_cmd_ff;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  a_clk_low_half: assert property (clk_fall |-> (!avs_clk)[*4] ##1 avs_clk)
    else $error("link clock low phase not four cycles");
  a_clk_high_half: assert property (clk_rise && rise_cnt_ff != 7'h3f
    |-> avs_clk[*4] ##1 !avs_clk)
    else $error("link clock high phase not four cycles");
  a_frame_len: assert property (frame_end && rise_cnt_ff != 7'h00
    |-> rise_cnt_ff == 7'h40)
    else $error("frame did not hold 64 link periods");
  a_start_bits: assert property (clk_fall && rise_cnt_ff == 7'h00
    |-> !mdata ##8 mdata)
    else $error("start code not sent as 0 then 1");
  a_read_ones: assert property (clk_fall && rd_cmd_ff && rise_cnt_ff >= 7'h0d
    && rise_cnt_ff <= 7'h1c |-> mdata)
    else $error("read command data not all ones");
  a_type_bit: assert property (clk_fall && rise_cnt_ff == 7'h04 |-> !mdata)
    else $error("command type bit not zero");
  a_mdata_setup: assert property (clk_rise && rise_cnt_ff < 7'h20 |-> $stable(mdata))
    else $error("master data moved at the sampling edge");
  a_resp_zero: assert property (clk_rise && rise_cnt_ff == 7'h22 |-> ##2 !sdata)
    else $error("response zero bit not low");
  a_resp_pad: assert property (clk_rise && rise_cnt_ff >= 7'h38 && rise_cnt_ff <= 7'h3c
    |-> ##2 sdata)
    else $error("response unused bits not high");
  a_mdata_idle: assert property (frame_end |-> mdata)
    else $error("master data not high when idle");

  c_frame: cover property (frame_end && rise_cnt_ff == 7'h40);
  c_start: cover property (clk_fall && rise_cnt_ff == 7'h00);
  c_pad: cover property (clk_rise && rise_cnt_ff == 7'h3c);
endmodule : avs_link_chk

/* verif/test_avs_bus_slave_frames.sv */
// bench joining host and device ends over the link, driven through wishbone
`timescale 1ns/1ps
module test_avs_bus_slave_frames
  import avs_pkg::*;
;
  typedef struct packed {
    logic [1:0]  acc;
    logic [3:0]  code;
    logic [3:0]  rail;
    logic [15:0] dat;
    logic [1:0]  ack;
    logic [15:0] rd;
  } avs_row_t;

  logic             ref_clk;
  logic             rst_n;
  logic             wb_cyc;
  logic             wb_stb;
  logic             wb_we;
  logic [3:0]       wb_sel;
  logic             bad_crc;
  logic [7:0]       wb_adr;
  logic [31:0]      wb_dat_wr;
  logic [31:0]      wb_dat_rd;
  logic             wb_ack;
  logic [1:0]       bus_ctrl;
  logic [1:0]       target_reached_flag;
  logic [1:0]       over_temperature_warning;
  logic [1:0][15:0] output_voltage_setpoint;
  logic [1:0][15:0] rail_current;
  logic [1:0][15:0] rail_temp;
  logic [1:0][15:0] target_mv;
  logic [1:0][15:0] trans_rate;
  logic [31:0]      resp;
  int               fails;
  int               check_count;
  int               cycles;
  // acc, code, rail, data, expected ack, expected data
  avs_row_t         rows [15] = '{
    '{ACC_READ, CMD_VTARGET, RAIL0, DATA_ONES, ACK_DONE, 16'h0384},
    '{ACC_READ, CMD_VTARGET, RAIL1, 16'h1234, ACK_DONE, 16'h04b0},
    '{ACC_READ, CMD_RATE, RAIL1, DATA_ONES, ACK_DONE, 16'h0000},
    '{ACC_READ, CMD_CURRENT, RAIL0, DATA_ONES, ACK_DONE, 16'h0123},
    '{ACC_READ, CMD_TEMP, RAIL1, DATA_ONES, ACK_DONE, 16'h0260},
    '{ACC_READ, CMD_STATUS, RAIL1, DATA_ONES, ACK_DONE, 16'h1000},
    '{ACC_READ, CMD_VERSION, RAIL_ALL, DATA_ONES, ACK_DONE, VERSION_VALUE},
    '{ACC_READ, CMD_VRESET, RAIL0, DATA_ONES, ACK_INVALID, DATA_ONES},
    '{ACC_READ, 4'h5, RAIL0, DATA_ONES, ACK_INVALID, DATA_ONES},
    '{ACC_READ, CMD_VTARGET, 4'h2, DATA_ONES, ACK_INVALID, DATA_ONES},
    '{ACC_WRITE, CMD_VTARGET, RAIL1, 16'h0320, ACK_DONE, DATA_ONES},
    '{ACC_WRITE, CMD_VTARGET, RAIL1, 16'h0320, ACK_NOACT, DATA_ONES},
    '{ACC_WRITE, CMD_RATE, RAIL_ALL, 16'h0a0a, ACK_DONE, DATA_ONES},
    '{2'h1, CMD_VTARGET, RAIL0, DATA_ONES, ACK_INVALID, DATA_ONES},
    '{ACC_READ, CMD_STATUS, RAIL0, DATA_ONES, ACK_DONE, 16'h8000}
  };

  avs_link_if avs_link_if_i ();

  avs_host_end avs_host_end_i (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc(wb_cyc),
    .wb_stb(wb_stb), .wb_we(wb_we), .wb_sel(wb_sel), .wb_adr(wb_adr), .wb_dat_wr(wb_dat_wr),
    .wb_dat_rd(wb_dat_rd), .wb_ack(wb_ack), .link(avs_link_if_i.host));

  avs_dev_end avs_dev_end_i (.ref_clk(ref_clk), .rst_n(rst_n), .link(avs_link_if_i.dev),
    .bus_ctrl(bus_ctrl), .output_voltage_setpoint(output_voltage_setpoint),
    .target_reached_flag(target_reached_flag),
    .over_temperature_warning(over_temperature_warning), .rail_current(rail_current),
    .rail_temp(rail_temp), .target_mv(target_mv), .trans_rate(trans_rate));

  avs_link_chk avs_link_chk_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .avs_clk(avs_link_if_i.avs_clk), .mdata(avs_link_if_i.mdata), .sdata(avs_link_if_i.sdata));

  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  function automatic logic [2:0] crc_of(input logic [28:0] d);
    logic [2:0] c;
    c = 3'h0;
    for (int i = 28; i >= 0; i--)
      c = {c[1], c[0] ^ d[i] ^ c[2], d[i] ^ c[2]};
    return c;
  endfunction : crc_of

  // status bits follow the addressed rail; broadcast and bad rails report rail 0
  function automatic logic [31:0] exp_resp(input logic [1:0] ack, input logic [3:0] rail,
                                           input logic [15:0] d);
    logic [28:0] h;
    logic        r;
    r = (rail == RAIL1);
    h = {ack, 1'b0, target_reached_flag[r], over_temperature_warning[r], bus_ctrl[r], 2'b00,
         d, PAD_ONES};
    return {h, crc_of(h)};
  endfunction : exp_resp

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                         output logic [31:0] rd);
    @(posedge ref_clk);
    wb_cyc    <= 1'b1;
    wb_stb    <= 1'b1;
    wb_we     <= we;
    wb_sel    <= 4'hf;
    wb_adr    <= adr;
    wb_dat_wr <= wd;
    do @(posedge ref_clk); while (wb_ack !== 1'b1);
    rd = wb_dat_rd;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
    wb_sel <= 4'h0;
  endtask : wb_xfer

  task automatic run_frame(input logic [1:0] acc, input logic [3:0] code, input logic [3:0] rail,
                           input logic [15:0] dat, output logic [31:0] r);
    logic [31:0] st;
    wb_xfer(1'b1, REG_CMD, {5'h00, bad_crc, acc, code, rail, dat}, st);
    wb_xfer(1'b0, REG_STAT, 32'h0, st);
    check("start status", 32'h1, {30'h0, st[SB_DONE], st[SB_BUSY]});
    while (st[SB_DONE] !== 1'b1)
      wb_xfer(1'b0, REG_STAT, 32'h0, st);
    check("end status", 32'h6, {29'h0, st[SB_CRC_OK], st[SB_DONE], st[SB_BUSY]});
    wb_xfer(1'b0, REG_RESP, 32'h0, r);
  endtask : run_frame

  // a stuck frame or handshake would otherwise hang the run
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      fails++;
      stop_test();
    end
  end

  initial
  begin
    rst_n = 1'b0;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_sel = 4'h0;
    bad_crc = 1'b0;
    wb_adr = 8'h00;
    wb_dat_wr = 32'h0;
    bus_ctrl = 2'h3;
    target_reached_flag = 2'h1;
    over_temperature_warning = 2'h2;
    output_voltage_setpoint = {16'h04b0, 16'h0384};
    rail_current = {16'h0456, 16'h0123};
    rail_temp = {16'h0260, 16'h0250};
    cycles = 0;
    fails = 0;
    check_count = 0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (12) @(posedge ref_clk);
    check("seeded target", 32'h0384, {16'h0, target_mv[0]});
    wb_xfer(1'b0, REG_STAT, 32'h0, resp);
    check("alert after reset", 32'h1, {31'h0, resp[SB_ALERT]});
    wb_xfer(1'b0, 8'h0c, 32'h0, resp);
    check("unmapped read", 32'h0, resp);
    foreach (rows[i])
    begin
      run_frame(rows[i].acc, rows[i].code, rows[i].rail, rows[i].dat, resp);
      check("row response", exp_resp(rows[i].ack, rows[i].rail, rows[i].rd), resp);
    end
    check("rail1 target", 32'h0320, {16'h0, target_mv[1]});
    check("broadcast rate", {16'h0a0a, 16'h0a0a}, {trans_rate[1], trans_rate[0]});
    bus_ctrl <= 2'h2;
    run_frame(ACC_WRITE, CMD_VTARGET, RAIL0, 16'h0400, resp);
    check("write without control", exp_resp(ACK_INVALID, RAIL0, DATA_ONES), resp);
    check("target kept", 32'h0384, {16'h0, target_mv[0]});
    run_frame(ACC_READ, CMD_VTARGET, RAIL0, DATA_ONES, resp);
    check("read without control", exp_resp(ACK_DONE, RAIL0, 16'h0384), resp);
    bus_ctrl <= 2'h3;
    run_frame(ACC_WRITE, CMD_VTARGET, RAIL0, 16'h0400, resp);
    check("write under control", exp_resp(ACK_DONE, RAIL0, DATA_ONES), resp);
    check("target written", 32'h0400, {16'h0, target_mv[0]});
    run_frame(ACC_WRITE, CMD_VRESET, RAIL0, 16'h0000, resp);
    check("voltage reset", exp_resp(ACK_DONE, RAIL0, DATA_ONES), resp);
    check("target restored", 32'h0384, {16'h0, target_mv[0]});
    bad_crc = 1'b1;
    run_frame(ACC_WRITE, CMD_VTARGET, RAIL0, 16'h0555, resp);
    bad_crc = 1'b0;
    check("bad crc", exp_resp(ACK_BADCRC, RAIL0, DATA_ONES), resp);
    check("target after bad crc", 32'h0384, {16'h0, target_mv[0]});
    target_reached_flag <= 2'h3;
    repeat (10) @(posedge ref_clk);
    wb_xfer(1'b0, REG_STAT, 32'h0, resp);
    check("alert on new bit", 32'h1, {31'h0, resp[SB_ALERT]});
    run_frame(ACC_READ, CMD_STATUS, RAIL1, DATA_ONES, resp);
    check("status entry", exp_resp(ACK_DONE, RAIL1, 16'h9000), resp);
    wb_xfer(1'b0, REG_STAT, 32'h0, resp);
    check("alert cleared", 32'h0, {31'h0, resp[SB_ALERT]});
    // reset between frames: entries clear, targets reseed on release
    rst_n <= 1'b0;
    @(posedge ref_clk);
    check("rate in reset", 32'h0, {trans_rate[1], trans_rate[0]});
    check("ack in reset", 32'h0, {31'h0, wb_ack});
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    check("reseeded targets", {16'h04b0, 16'h0384}, {target_mv[1], target_mv[0]});
    run_frame(ACC_READ, CMD_RATE, RAIL0, DATA_ONES, resp);
    check("rate after reset", exp_resp(ACK_DONE, RAIL0, 16'h0000), resp);
    stop_test();
  end
endmodule : test_avs_bus_slave_frames
